// File: rtl/rtc_pkg.sv
// Purpose: shared constants, calendar type and helpers for the rtc block
// Assumes: 32.768 kHz crystal sampled by a 200 MHz system clock
// Notes:   calendar fields are binary, year 0 stands for 2000
package rtc_pkg;

  localparam int          SYS_HZ          = 200_000_000;
  localparam int          SLOW_HZ         = 32768;
  localparam int          TRIM_STEPS      = 16;
  // one second expressed in sixteenths of a crystal period
  localparam logic [19:0] SEC_UNITS       = 20'(SLOW_HZ * TRIM_STEPS);
  localparam logic [19:0] ACC_STEP        = 20'(TRIM_STEPS);
  localparam logic [19:0] ACC_RESET       = 20'h0_0000;
  localparam logic [5:0]  SEC_LAST        = 6'h3B;
  localparam logic [5:0]  MIN_LAST        = 6'h3B;
  localparam logic [4:0]  HOUR_LAST       = 5'h17;
  localparam logic [3:0]  MONTH_LAST      = 4'hC;
  localparam logic [5:0]  YEAR_LAST       = 6'h3F;
  localparam logic [4:0]  DAY_FIRST       = 5'h01;
  localparam logic [3:0]  MONTH_FIRST     = 4'h1;
  localparam logic [11:0] BLINK_UNIT_LAST = 12'hFFF;
  localparam logic [19:0] BLINK_RESET     = 20'h0_0000;
  localparam logic [31:0] SECCNT_RESET    = 32'h0000_0000;

  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } cal_t;

  localparam cal_t CAL_RESET = '0;

  // years 2000..2063 are leap exactly when divisible by four
  function automatic logic [4:0] days_in_month(input logic [3:0] month,
                                               input logic [5:0] year);
    logic [4:0] d;
    d = 5'h1F;
    case (month)
      4'h2:                d = (year[1:0] == 2'h0) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9,
      4'hB:                d = 5'h1E;
      default:             d = 5'h1F;
    endcase
    return d;
  endfunction

endpackage

// File: rtl/rtc_tick_if.sv
// Purpose: carries crystal edges and trim to the second prescaler
// Assumes: all signals in the system clock domain
// Notes:   sec_pulse is one system cycle wide
`timescale 1ns/1ps
interface rtc_tick_if;
  logic             slow_edge;  // one cycle per crystal period
  logic signed [7:0] trim;      // sixteenths of a period per second
  logic             sec_pulse;  // trimmed one-second strobe

  modport core      (output slow_edge, output trim, input sec_pulse);
  modport prescaler (input slow_edge, input trim, output sec_pulse);
endinterface

// File: rtl/rtc_second_prescaler.sv
// Purpose: divides crystal edges to a trimmed one-second strobe
// Assumes: slow_edge never comes on two adjacent cycles
// Notes:   positive trim shortens the second, speeding the calendar
`timescale 1ns/1ps
module rtc_second_prescaler
  import rtc_pkg::*;
(
  input  wire logic clk,        // system clock
  input  wire logic rst_n,      // synchronised reset, active low
  rtc_tick_if.prescaler lnk     // edges in, seconds out
);

  typedef struct packed {
    logic [19:0] acc;
    logic        pulse;
  } pre_state_t;

  pre_state_t  st;
  pre_state_t  next_st;
  logic [19:0] sum;
  logic [19:0] thr;

  always_comb begin
    next_st       = st;
    next_st.pulse = 1'b0;
    sum = st.acc + ACC_STEP;
    // fractional accumulator: each crystal edge adds 16 units of 1/16 period
    thr = SEC_UNITS - {{12{lnk.trim[7]}}, lnk.trim};
    if (lnk.slow_edge) begin
      if (sum >= thr) begin
        next_st.acc   = sum - thr;
        next_st.pulse = 1'b1;
      end else begin
        next_st.acc = sum;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{acc: ACC_RESET, pulse: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign lnk.sec_pulse = st.pulse;

  property p_pulse_on_edge;
    @(posedge clk) disable iff (!rst_n)
      st.pulse |-> $past(lnk.slow_edge);
  endproperty
  a_pulse_on_edge: assert property (p_pulse_on_edge)
    else $error("second strobe without crystal edge");

endmodule

// File: rtl/rtc_calendar.sv
// Purpose: calendar, alarm, tick, seconds counter and blink outputs
// Assumes: crystal, supply and power-on signals are asynchronous pins
// Notes:   host accesses are plain strobed ports, no register bus
//
// Function
// - count crystal periods into seconds, minutes, hours, day, month, year
// - year zero means 2000, range reaches 63
// - host can read and write the calendar
// - calendar clears to zero when core supply is lost
// - alarm match on minute to year raises event, wake in power-down
// - each trigger sets the alarm event flag
// - periodic tick every second or every minute as selected
// - source status tells calendar match from tick
// - alarm and tick enabled independently
// - monitor flag clears at power-up, software sets it
// - 32-bit seconds counter cleared by power-on reset and by resetn
// - two blink outputs toggle periodically, running in power-down
// - trim up to 242 ppm in 1.9 ppm steps
// - trim acts only on counting, clock output untrimmed
// - sequencer may gate clock output off in power-down
`timescale 1ns/1ps
module rtc_calendar
  import rtc_pkg::*;
(
  input  wire logic        clk,              // 200 MHz system clock
  input  wire logic        resetn,           // async reset, active low
  input  wire logic        power_on_reset_n, // pin, clears seconds counter
  input  wire logic        xtal_clk_in,      // 32.768 kHz crystal pin
  input  wire logic        core_supply_rail, // pin, high while supply good
  input  wire logic        power_down,       // device in power-down
  input  wire logic        out_gate_off,     // sequencer gates clock out
  input  wire logic        time_wr,          // strobe: load calendar
  input  wire cal_t        time_in,          // calendar write value
  input  wire logic        alarm_wr,         // strobe: load alarm
  input  wire cal_t        alarm_in,         // alarm value, sec ignored
  input  wire logic        alarm_on,         // calendar alarm enable
  input  wire logic        tick_on,          // periodic tick enable
  input  wire logic        tick_per_min,     // 1: tick per minute
  input  wire logic [7:0]  trim,             // signed trim, 1/16 period
  input  wire logic        monitor_set,      // strobe: set monitor flag
  input  wire logic        alarm_flag_clr,   // strobe: clear alarm flag
  input  wire logic        blink_en_a,       // enable blink output a
  input  wire logic        blink_en_b,       // enable blink output b
  input  wire logic [7:0]  blink_period,     // half period, 1/8 s units, minus one
  output cal_t             time_out,         // running calendar
  output cal_t             alarm_out,        // stored alarm
  output logic             monitor,          // clock-valid monitor flag
  output logic             alarm_flag,       // sticky alarm event flag
  output logic             alarm_src_tick,   // 1: last event was tick
  output logic             event_pulse,      // one-cycle event
  output logic             wake_pulse,       // one-cycle wake-up
  output logic [31:0]      seconds_count,    // free-running seconds
  output logic             blink_output_a,   // blink pin a
  output logic             blink_output_b,   // blink pin b
  output logic             slow_clock_out    // buffered crystal clock
);

  typedef struct packed {
    logic [1:0]  xtal_s;
    logic        xtal_d;
    logic        slow_edge;
    logic [1:0]  sup_s;
    logic [1:0]  por_s;
    cal_t        cal;
    cal_t        alarm;
    logic        monitor;
    logic        flag;
    logic        src_tick;
    logic        irq;
    logic        wake;
    logic        match_prev;
    logic [31:0] sec_cnt;
    logic [19:0] blink_cnt;
    logic        blink_a;
    logic        blink_b;
    logic        clk_out;
  } cal_state_t;

  cal_state_t st;
  cal_state_t next_st;
  logic [1:0] rst_pipe;
  logic       rst_n;
  logic       match;
  logic       alarm_hit;
  logic       tick_hit;

  rtc_tick_if lnk ();

  rtc_second_prescaler u_pre (
    .clk   (clk),
    .rst_n (rst_n),
    .lnk   (lnk)
  );

  assign lnk.slow_edge = st.slow_edge;
  assign lnk.trim      = trim;

  // reset asserts at once, releases after two clean edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  function automatic cal_t cal_advance(input cal_t c);
    cal_t r;
    r = c;
    if (c.sec < SEC_LAST) begin
      r.sec = c.sec + 6'h01;
    end else begin
      r.sec = 6'h00;
      if (c.min < MIN_LAST) begin
        r.min = c.min + 6'h01;
      end else begin
        r.min = 6'h00;
        if (c.hour < HOUR_LAST) begin
          r.hour = c.hour + 5'h01;
        end else begin
          r.hour = 5'h00;
          if (c.day < days_in_month(c.month, c.year)) begin
            r.day = c.day + 5'h01;
          end else begin
            r.day = DAY_FIRST;
            if (c.month < MONTH_LAST) begin
              r.month = c.month + 4'h1;
            end else begin
              r.month = MONTH_FIRST;
              r.year  = c.year + 6'h01;
            end
          end
        end
      end
    end
    return r;
  endfunction

  assign tick_hit  = tick_on && lnk.sec_pulse &&
                     (!tick_per_min || st.cal.sec == SEC_LAST);

  always_comb begin
    next_st           = st;
    next_st.xtal_s    = {st.xtal_s[0], xtal_clk_in};
    next_st.xtal_d    = st.xtal_s[1];
    next_st.slow_edge = st.xtal_s[1] && !st.xtal_d;
    next_st.sup_s     = {st.sup_s[0], core_supply_rail};
    next_st.por_s     = {st.por_s[0], power_on_reset_n};
    // raw crystal, never the trimmed count, drives the pin
    next_st.clk_out   = st.xtal_s[1] &&
                        !(power_down && out_gate_off);

    if (lnk.sec_pulse) begin
      next_st.cal = cal_advance(st.cal);
    end
    if (time_wr) begin
      next_st.cal = time_in;
    end
    if (alarm_wr) begin
      next_st.alarm = alarm_in;
    end
    if (monitor_set) begin
      next_st.monitor = 1'b1;
    end
    if (!st.sup_s[1]) begin
      next_st.cal     = CAL_RESET;
      next_st.monitor = 1'b0;
    end

    if (!st.por_s[1]) begin
      next_st.sec_cnt = SECCNT_RESET;
    end else if (lnk.sec_pulse) begin
      next_st.sec_cnt = st.sec_cnt + 32'h0000_0001;
    end

    // next value compared, so a minute tick on the same roll merges
    match     = alarm_on && (next_st.cal.sec == 6'h00) &&
                (next_st.cal[31:6] == next_st.alarm[31:6]);
    alarm_hit = match && !st.match_prev;
    next_st.match_prev = match;
    next_st.irq  = alarm_hit || tick_hit;
    next_st.wake = (alarm_hit || tick_hit) && power_down;
    if (alarm_hit || tick_hit) begin
      next_st.src_tick = !alarm_hit;
    end
    // a hit in the clear cycle wins, so no event is lost
    if (alarm_flag_clr) begin
      next_st.flag = 1'b0;
    end
    if (alarm_hit || tick_hit) begin
      next_st.flag = 1'b1;
    end

    // counts crystal edges, so blinking survives power-down
    if (st.slow_edge) begin
      if (st.blink_cnt == {blink_period, BLINK_UNIT_LAST}) begin
        next_st.blink_cnt = BLINK_RESET;
        next_st.blink_a   = st.blink_a ^ blink_en_a;
        next_st.blink_b   = st.blink_b ^ blink_en_b;
      end else begin
        next_st.blink_cnt = st.blink_cnt + 20'h0_0001;
      end
    end
    if (!blink_en_a) begin
      next_st.blink_a = 1'b0;
    end
    if (!blink_en_b) begin
      next_st.blink_b = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign time_out       = st.cal;
  assign alarm_out      = st.alarm;
  assign monitor        = st.monitor;
  assign alarm_flag     = st.flag;
  assign alarm_src_tick = st.src_tick;
  assign event_pulse    = st.irq;
  assign wake_pulse     = st.wake;
  assign seconds_count  = st.sec_cnt;
  assign blink_output_a = st.blink_a;
  assign blink_output_b = st.blink_b;
  assign slow_clock_out = st.clk_out;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cal_clear;
    !st.sup_s[1] |=> st.cal == CAL_RESET && !st.monitor;
  endproperty
  a_cal_clear: assert property (p_cal_clear)
    else $error("calendar not cleared on supply loss");
  property p_sec_step;
    lnk.sec_pulse && !time_wr && st.sup_s[1] && st.cal.sec < SEC_LAST
      |=> st.cal.sec == $past(st.cal.sec) + 6'h01;
  endproperty
  a_sec_step: assert property (p_sec_step)
    else $error("seconds did not advance");
  property p_alarm_event;
    alarm_hit |=> event_pulse && alarm_flag && !alarm_src_tick;
  endproperty
  a_alarm_event: assert property (p_alarm_event)
    else $error("alarm match did not raise event");
  property p_wake;
    (alarm_hit || tick_hit) && power_down |=> wake_pulse;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake in power-down");
  property p_flag_sticky;
    alarm_flag && !alarm_flag_clr |=> alarm_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("alarm flag dropped without clear");
  property p_event_single;
    event_pulse |=> !event_pulse;
  endproperty
  a_event_single: assert property (p_event_single)
    else $error("event longer than one cycle");
  property p_disabled;
    !alarm_on && !tick_on |=> !event_pulse;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("event while both sources disabled");
  property p_tick_minute;
    tick_on && tick_per_min && !alarm_hit && st.cal.sec != SEC_LAST
      |=> !event_pulse;
  endproperty
  a_tick_minute: assert property (p_tick_minute)
    else $error("minute tick fired mid-minute");
  property p_seccnt_por;
    !st.por_s[1] |=> seconds_count == SECCNT_RESET;
  endproperty
  a_seccnt_por: assert property (p_seccnt_por)
    else $error("seconds counter not cleared by power-on reset");
  property p_out_gate;
    power_down && out_gate_off |=> !slow_clock_out;
  endproperty
  a_out_gate: assert property (p_out_gate)
    else $error("clock output not gated");
  property p_blink_off;
    !blink_en_a |=> !blink_output_a;
  endproperty
  a_blink_off: assert property (p_blink_off)
    else $error("blink a active while disabled");
  c_alarm: cover property (alarm_hit);
  c_tick_both: cover property (tick_hit && alarm_on);
  c_wake: cover property (wake_pulse);
  c_year_roll: cover property (lnk.sec_pulse && st.cal.year == YEAR_LAST);

endmodule

// File: testbench/rtc_xtal_model.sv
// Purpose: crystal source standing in for the 32.768 kHz oscillator
// Assumes: bench shortens the crystal period to keep the run short
// Notes:   free running, as a started oscillator is; phase kept off clk
`timescale 1ns/1ps
module rtc_xtal_model #(
  parameter realtime HALF   = 5.0,  // half period in ns
  parameter realtime OFFSET = 1.0   // phase away from clk edges
) (
  output logic xtal_clk             // crystal pin drive
);
  initial begin
    xtal_clk = 1'b0;
    #OFFSET;
    forever #HALF xtal_clk = ~xtal_clk;
  end
endmodule

// File: testbench/rtc_calendar_alarm_tick_tb.sv
// Purpose: self-checking bench for the rtc calendar block
// Assumes: crystal edge every 2 clk cycles, so one second is 65536 cycles
// Notes:   two seconds are run; blink and clock gating fit in the first
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
  err_total++; $display("wrong value %s expected %0h seen %0h", nm, exp, \
  got); end end
module rtc_calendar_alarm_tick_tb;
  import rtc_pkg::*;
  logic        clk, resetn, power_on_reset_n, xtal_clk_in;
  logic        core_supply_rail, power_down, out_gate_off, time_wr;
  logic        alarm_wr, alarm_on, tick_on, tick_per_min, monitor_set;
  logic        alarm_flag_clr, blink_en_a, blink_en_b;
  logic [7:0]  trim, blink_period;
  cal_t        time_in, alarm_in, time_out, alarm_out;
  logic        monitor, alarm_flag, alarm_src_tick, event_pulse, wake_pulse;
  logic        blink_output_a, blink_output_b, slow_clock_out;
  logic [31:0] seconds_count, prev_count;
  int          err_total, checked, n, ev_count, sec_gap, gap_run;
  localparam cal_t LAST_VAL = '{6'h3F, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3B};
  localparam cal_t NEW_YEAR = '{6'h00, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00};
  localparam cal_t ONE_SEC  = '{6'h00, 4'h1, 5'h01, 5'h00, 6'h00, 6'h01};

  rtc_xtal_model i_rtc_xtal_model (.xtal_clk(xtal_clk_in));
  rtc_calendar i_rtc_calendar (
    .clk(clk), .resetn(resetn), .power_on_reset_n(power_on_reset_n),
    .xtal_clk_in(xtal_clk_in), .core_supply_rail(core_supply_rail),
    .power_down(power_down), .out_gate_off(out_gate_off),
    .time_wr(time_wr), .time_in(time_in), .alarm_wr(alarm_wr),
    .alarm_in(alarm_in), .alarm_on(alarm_on), .tick_on(tick_on),
    .tick_per_min(tick_per_min), .trim(trim), .monitor_set(monitor_set),
    .alarm_flag_clr(alarm_flag_clr), .blink_en_a(blink_en_a),
    .blink_en_b(blink_en_b), .blink_period(blink_period),
    .time_out(time_out), .alarm_out(alarm_out), .monitor(monitor),
    .alarm_flag(alarm_flag), .alarm_src_tick(alarm_src_tick),
    .event_pulse(event_pulse), .wake_pulse(wake_pulse),
    .seconds_count(seconds_count), .blink_output_a(blink_output_a),
    .blink_output_b(blink_output_b), .slow_clock_out(slow_clock_out)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // second length and event count watched beside the main sequence
  always @(negedge clk) begin
    gap_run++;
    if (event_pulse === 1'b1) ev_count++;
    if (seconds_count !== prev_count) begin
      sec_gap = gap_run;
      gap_run = 0;
    end
    prev_count = seconds_count;
  end

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wait_event();
    n = 0;
    while (event_pulse !== 1'b1 && n < 70000) begin
      cyc(1);
      n++;
    end
    if (n >= 70000) begin
      err_total++;
      $display("wrong value event_pulse expected 1 seen 0");
    end
  endtask

  task automatic host_wr(input bit to_alarm, input cal_t v);
    time_in = v;
    alarm_in = v;
    time_wr = !to_alarm;
    alarm_wr = to_alarm;
    cyc(1);
    time_wr = 1'b0;
    alarm_wr = 1'b0;
    cyc(1);
  endtask

  task automatic count_rises(output int r);
    logic last;
    r = 0;
    last = slow_clock_out;
    repeat (200) begin
      cyc(1);
      if (slow_clock_out === 1'b1 && last !== 1'b1) r++;
      last = slow_clock_out;
    end
  endtask

  task automatic tally_and_finish();
    $display("counts: checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    err_total++;
    $display("watchdog ran out");
    tally_and_finish();
  end

  initial begin
    {resetn, power_on_reset_n, power_down, out_gate_off, time_wr} = '0;
    {alarm_wr, alarm_on, tick_on, tick_per_min, monitor_set} = '0;
    {alarm_flag_clr, blink_en_a, blink_en_b} = '0;
    core_supply_rail = 1'b1;
    trim = 8'h00;
    blink_period = 8'h00;
    time_in = CAL_RESET;
    alarm_in = CAL_RESET;
    {err_total, checked, ev_count, gap_run, sec_gap} = '0;
    prev_count = SECCNT_RESET;
    cyc(8);
    resetn = 1'b1;
    power_on_reset_n = 1'b1;
    cyc(4);
    `CHK("time_out", CAL_RESET, time_out)
    `CHK("seconds_count", SECCNT_RESET, seconds_count)
    `CHK("monitor", 1'b0, monitor)
    $display("test reset done");
    tick_on = 1'b1;
    tick_per_min = 1'b1;
    host_wr(1'b0, LAST_VAL);
    `CHK("time_out", LAST_VAL, time_out)
    host_wr(1'b1, NEW_YEAR);
    `CHK("alarm_out", NEW_YEAR, alarm_out)
    monitor_set = 1'b1;
    cyc(1);
    monitor_set = 1'b0;
    cyc(1);
    `CHK("monitor", 1'b1, monitor)
    $display("test host write done");
    blink_en_a = 1'b1;
    alarm_on = 1'b1;
    n = 0;
    while (blink_output_a !== 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (blink_output_a === 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    `CHK("blink half period", 32'h0000_2000, n)
    `CHK("blink_output_b", 1'b0, blink_output_b)
    out_gate_off = 1'b1;
    count_rises(n);
    `CHK("clock out active", 32'h0000_0064, n)
    power_down = 1'b1;
    count_rises(n);
    `CHK("clock out gated", 32'h0000_0000, n)
    out_gate_off = 1'b0;
    count_rises(n);
    `CHK("clock out power down", 32'h0000_0064, n)
    $display("test blink and clock out done");
    // minute tick and match on one roll give a single match event
    wait_event();
    `CHK("wake_pulse", 1'b1, wake_pulse)
    `CHK("time_out", NEW_YEAR, time_out)
    `CHK("seconds_count", 32'h0000_0001, seconds_count)
    `CHK("alarm_src_tick", 1'b0, alarm_src_tick)
    trim = 8'h10;
    tick_per_min = 1'b0;
    power_down = 1'b0;
    cyc(1);
    `CHK("event_pulse", 1'b0, event_pulse)
    `CHK("alarm_flag", 1'b1, alarm_flag)
    alarm_flag_clr = 1'b1;
    cyc(1);
    alarm_flag_clr = 1'b0;
    cyc(1);
    `CHK("alarm_flag", 1'b0, alarm_flag)
    $display("test alarm match done");
    // one period trimmed off: 32767 edges of 2 cycles each
    wait_event();
    `CHK("wake_pulse", 1'b0, wake_pulse)
    `CHK("alarm_src_tick", 1'b1, alarm_src_tick)
    `CHK("time_out", ONE_SEC, time_out)
    cyc(4);
    `CHK("second length", 32'h0000_FFFE, sec_gap)
    `CHK("event count", 32'h0000_0002, ev_count)
    `CHK("alarm_flag", 1'b1, alarm_flag)
    $display("test tick and trim done");
    core_supply_rail = 1'b0;
    cyc(6);
    `CHK("time_out", CAL_RESET, time_out)
    `CHK("monitor", 1'b0, monitor)
    `CHK("alarm_out", NEW_YEAR, alarm_out)
    `CHK("seconds_count", 32'h0000_0002, seconds_count)
    core_supply_rail = 1'b1;
    power_on_reset_n = 1'b0;
    cyc(6);
    `CHK("seconds_count", SECCNT_RESET, seconds_count)
    power_on_reset_n = 1'b1;
    $display("test supply loss done");
    tally_and_finish();
  end
endmodule
